// File: src/gak_pkg.sv
package gak_pkg;

  // reference clock
  localparam int unsigned GAK_REF_MHZ = 50;

  // register offsets on the plain register port
  localparam logic [7:0] GAK_ADDR_CONFIG = 8'hF0;
  localparam logic [7:0] GAK_ADDR_STATUS = 8'hF1;
  localparam logic [7:0] GAK_ADDR_FAST = 8'h92;

  // reset values and writable masks
  localparam logic [7:0] GAK_CONFIG_RESET = 8'h80;
  localparam logic [7:0] GAK_CONFIG_WMASK = 8'hC7;
  localparam logic [7:0] GAK_FAST_RESET = 8'h24;
  localparam logic [7:0] GAK_FAST_FIXED = 8'h24;

  // configuration field positions
  localparam int unsigned GAK_CFG_RATE_HI = 7;
  localparam int unsigned GAK_CFG_RATE_LO = 6;
  localparam int unsigned GAK_CFG_FAST_EN = 2;
  localparam int unsigned GAK_CFG_HW_GATE = 1;
  localparam int unsigned GAK_CFG_HW_RST = 0;

  // fast control register field positions
  localparam int unsigned GAK_FAST_GATE = 1;
  localparam int unsigned GAK_FAST_PULSE = 0;

  // data byte after a write-output command: bit positions
  localparam int unsigned GAK_DATA_GATE = 1;
  localparam int unsigned GAK_DATA_RESET = 0;

  // status register bit positions; bit 2 reads zero
  localparam int unsigned GAK_STS_GATE_OUT = 0;
  localparam int unsigned GAK_STS_RESET_OUT = 1;
  localparam int unsigned GAK_STS_HW_RESET = 3;
  localparam int unsigned GAK_STS_HW_GATE = 4;
  localparam int unsigned GAK_STS_FAST_BUSY = 5;
  localparam int unsigned GAK_STS_KBC_BUSY = 6;
  localparam int unsigned GAK_STS_AWAIT_DATA = 7;

  // controller output latches after reset: gate closed, reset not asserted
  localparam logic GAK_HW_GATE_RESET = 1'b0;
  localparam logic GAK_HW_RESET_RESET = 1'b1;

  // controller commands
  localparam logic [7:0] GAK_CMD_WRITE_OUT = 8'hD1;
  localparam logic [7:0] GAK_CMD_PULSE_RESET = 8'hFE;

  // reset pulse timing, least values
  localparam int unsigned GAK_DELAY_NS = 14000;
  localparam int unsigned GAK_PULSE_NS = 6000;

  // selectable controller clock rates
  localparam int unsigned GAK_RATE6_MHZ = 6;
  localparam int unsigned GAK_RATE12_MHZ = 12;
  localparam int unsigned GAK_RATE16_MHZ = 16;

  // least times round up to whole controller clock periods
  localparam int unsigned GAK_DELAY_CNT6 = (GAK_DELAY_NS * GAK_RATE6_MHZ + 999) / 1000;
  localparam int unsigned GAK_PULSE_CNT6 = (GAK_PULSE_NS * GAK_RATE6_MHZ + 999) / 1000;
  localparam int unsigned GAK_DELAY_CNT12 = (GAK_DELAY_NS * GAK_RATE12_MHZ + 999) / 1000;
  localparam int unsigned GAK_PULSE_CNT12 = (GAK_PULSE_NS * GAK_RATE12_MHZ + 999) / 1000;
  localparam int unsigned GAK_DELAY_CNT16 = (GAK_DELAY_NS * GAK_RATE16_MHZ + 999) / 1000;
  localparam int unsigned GAK_PULSE_CNT16 = (GAK_PULSE_NS * GAK_RATE16_MHZ + 999) / 1000;

  localparam int unsigned GAK_CNT_W = 8;
  localparam int unsigned GAK_ACC_W = 6;

  typedef enum logic [1:0] {
    GAK_RATE_6 = 2'b00,
    GAK_RATE_RSVD = 2'b01,
    GAK_RATE_12 = 2'b10,
    GAK_RATE_16 = 2'b11
  } gak_rate_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gak_bus_req_type;

  typedef struct packed {
    logic is_command;
    logic [7:0] value;
  } gak_host_byte_type;

endpackage : gak_pkg

// File: src/gak_reset_pulser.sv
`timescale 1ns/10ps
`default_nettype none
module gak_reset_pulser #(
  parameter int unsigned CNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // timing
  input wire logic tick,
  input wire logic [CNT_W-1:0] delay_cnt,
  input wire logic [CNT_W-1:0] pulse_cnt,
  // control
  input wire logic start,
  input wire logic cancel,
  // status
  output logic pulse_low,
  output logic busy
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_PULSE
  } gak_pulse_state_type;

  gak_pulse_state_type state;
  logic [CNT_W-1:0] cnt;

  if (CNT_W < 2 || CNT_W > 16)
  begin : g_bad_cnt_w
    $error("CNT_W out of range");
  end

  // counting one tick past the figure covers the unknown phase of the first tick
  always_ff @(posedge ref_clk)
  begin
    if (rst || cancel)
    begin
      state <= ST_IDLE;
      cnt <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          cnt <= '0;
          if (start)
            state <= ST_DELAY;
        end
        ST_DELAY:
        begin
          if (tick)
          begin
            if (cnt == delay_cnt)
            begin
              cnt <= '0;
              state <= ST_PULSE;
            end
            else
              cnt <= cnt + 1'b1;
          end
        end
        ST_PULSE:
        begin
          if (tick)
          begin
            if (cnt == pulse_cnt)
            begin
              cnt <= '0;
              state <= ST_IDLE;
            end
            else
              cnt <= cnt + 1'b1;
          end
        end
        default:
        begin
          cnt <= '0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign pulse_low = (state == ST_PULSE);
  assign busy = (state != ST_IDLE);

endmodule : gak_reset_pulser
`default_nettype wire

// File: src/gak_gate_reset_ctrl.sv
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module gak_gate_reset_ctrl
  import gak_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire gak_bus_req_type bus_req,
  output logic [7:0] rd_data,
  // bytes written to the keyboard controller
  input wire logic host_byte_valid,
  input wire gak_host_byte_type host_byte,
  // firmware levels used while the hardware paths are off
  input wire logic sw_addr_gate_level,
  input wire logic sw_kbd_reset_n,
  // outputs to chipset and processor
  output logic addr_line20_gate,
  output logic kbd_reset_out_n
);

  // configuration register fields
  logic [7:0] kbd_hw_control_config;
  logic clk_rate_sel_hi;
  logic clk_rate_sel_lo;
  logic fast_port_enable;
  logic hw_addr_gate_enable;
  logic hw_kbd_reset_enable;

  // fast control register fields
  logic soft_addr_gate_level;
  logic soft_kbd_reset_pulse;
  logic [7:0] fast_a20_reset_port;

  // rate handling
  gak_rate_type rate_sel;
  logic [GAK_ACC_W-1:0] rate_step;
  logic [GAK_CNT_W-1:0] delay_cnt;
  logic [GAK_CNT_W-1:0] pulse_cnt;
  logic [GAK_ACC_W-1:0] phase_acc;
  logic [GAK_ACC_W:0] phase_sum;
  logic kbc_tick;

  // controller command tracking
  logic await_write_data;
  logic write_out_cmd;
  logic pulse_reset_cmd;
  logic hw_gate_level;
  logic hw_reset_level;
  logic write_out_data;
  logic kbc_pulse_start;
  logic kbc_pulse_low;
  logic kbc_pulse_busy;

  // fast register pulse
  logic fast_write;
  logic fast_pulse_start;
  logic fast_pulse_low;
  logic fast_pulse_busy;

  // one pulse timer per reset source
  logic [1:0] pulse_start;
  logic [1:0] pulse_cancel;
  logic [1:0] pulse_low;
  logic [1:0] pulse_busy;

  // merged sources
  logic kbc_gate_req;
  logic kbc_reset_low;
  logic fast_gate_req;
  logic fast_reset_low;
  logic next_addr_line20_gate;
  logic next_kbd_reset_out_n;

  logic [7:0] status_word;

  assign clk_rate_sel_hi = kbd_hw_control_config[GAK_CFG_RATE_HI];
  assign clk_rate_sel_lo = kbd_hw_control_config[GAK_CFG_RATE_LO];
  assign fast_port_enable = kbd_hw_control_config[GAK_CFG_FAST_EN];
  assign hw_addr_gate_enable = kbd_hw_control_config[GAK_CFG_HW_GATE];
  assign hw_kbd_reset_enable = kbd_hw_control_config[GAK_CFG_HW_RST];

  // ---------------------------------------------------------------
  // elaboration checks on the shared constants
  // ---------------------------------------------------------------
  // the divider takes the reference away once per overflow, so each rate must lie below it
  if (GAK_RATE16_MHZ >= GAK_REF_MHZ || GAK_RATE12_MHZ >= GAK_REF_MHZ
    || GAK_RATE6_MHZ >= GAK_REF_MHZ)
  begin : g_bad_rate
    $error("controller rate not below the reference clock");
  end
  if (GAK_REF_MHZ >= (1 << GAK_ACC_W))
  begin : g_bad_acc_w
    $error("GAK_ACC_W too narrow for the reference clock");
  end
  // the fastest rate has the longest counts
  if (GAK_DELAY_CNT16 >= (1 << GAK_CNT_W) || GAK_PULSE_CNT16 >= (1 << GAK_CNT_W))
  begin : g_bad_cnt_w
    $error("GAK_CNT_W too narrow for the pulse counts");
  end
  // the read value is built over the fixed pattern, so both fields must be clear in it
  if (GAK_FAST_FIXED[GAK_FAST_GATE] || GAK_FAST_FIXED[GAK_FAST_PULSE])
  begin : g_bad_fixed
    $error("fixed read pattern overlaps the fast register fields");
  end
  // the rate code is read as one two-bit field
  if (GAK_CFG_RATE_HI != GAK_CFG_RATE_LO + 1)
  begin : g_bad_rate_field
    $error("rate field bits not adjacent");
  end

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      kbd_hw_control_config <= GAK_CONFIG_RESET;
    else if (bus_req.wr && bus_req.addr == GAK_ADDR_CONFIG)
      kbd_hw_control_config <= bus_req.wdata & GAK_CONFIG_WMASK;
  end

  // ---------------------------------------------------------------
  // fast control register
  // ---------------------------------------------------------------
  assign fast_write = bus_req.wr && bus_req.addr == GAK_ADDR_FAST;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      soft_addr_gate_level <= GAK_FAST_RESET[GAK_FAST_GATE];
      soft_kbd_reset_pulse <= GAK_FAST_RESET[GAK_FAST_PULSE];
    end
    else if (fast_write)
    begin
      soft_addr_gate_level <= bus_req.wdata[GAK_FAST_GATE];
      soft_kbd_reset_pulse <= bus_req.wdata[GAK_FAST_PULSE];
    end
  end

  // only a 0 to 1 change of bit 0 asks for a pulse; a held 1 does not repeat
  assign fast_pulse_start = fast_write && fast_port_enable
    && bus_req.wdata[GAK_FAST_PULSE] && !soft_kbd_reset_pulse;

  // reserved bits are fixed, so the read value is built rather than stored
  always_comb
  begin
    fast_a20_reset_port = GAK_FAST_FIXED;
    fast_a20_reset_port[GAK_FAST_GATE] = soft_addr_gate_level;
    fast_a20_reset_port[GAK_FAST_PULSE] = soft_kbd_reset_pulse;
  end

  // ---------------------------------------------------------------
  // controller clock rate
  // ---------------------------------------------------------------
  assign rate_sel = gak_rate_type'({clk_rate_sel_hi, clk_rate_sel_lo});

  // the undefined code falls back to the slowest rate, the longest pulse
  always_comb
  begin
    case (rate_sel)
      GAK_RATE_12:
      begin
        rate_step = GAK_ACC_W'(GAK_RATE12_MHZ);
        delay_cnt = GAK_CNT_W'(GAK_DELAY_CNT12);
        pulse_cnt = GAK_CNT_W'(GAK_PULSE_CNT12);
      end
      GAK_RATE_16:
      begin
        rate_step = GAK_ACC_W'(GAK_RATE16_MHZ);
        delay_cnt = GAK_CNT_W'(GAK_DELAY_CNT16);
        pulse_cnt = GAK_CNT_W'(GAK_PULSE_CNT16);
      end
      default:
      begin
        rate_step = GAK_ACC_W'(GAK_RATE6_MHZ);
        delay_cnt = GAK_CNT_W'(GAK_DELAY_CNT6);
        pulse_cnt = GAK_CNT_W'(GAK_PULSE_CNT6);
      end
    endcase
  end

  // fractional divider: one enable per controller clock period on average
  assign phase_sum = {1'b0, phase_acc} + {1'b0, rate_step};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      phase_acc <= '0;
      kbc_tick <= 1'b0;
    end
    else if (phase_sum >= (GAK_ACC_W + 1)'(GAK_REF_MHZ))
    begin
      phase_acc <= GAK_ACC_W'(phase_sum - (GAK_ACC_W + 1)'(GAK_REF_MHZ));
      kbc_tick <= 1'b1;
    end
    else
    begin
      phase_acc <= phase_sum[GAK_ACC_W-1:0];
      kbc_tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // controller command decode
  // ---------------------------------------------------------------
  assign write_out_cmd = host_byte_valid && host_byte.is_command
    && host_byte.value == GAK_CMD_WRITE_OUT;
  assign pulse_reset_cmd = host_byte_valid && host_byte.is_command
    && host_byte.value == GAK_CMD_PULSE_RESET;
  assign write_out_data = host_byte_valid && !host_byte.is_command && await_write_data;

  // any other byte cancels a pending write-output command
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      await_write_data <= 1'b0;
    else if (host_byte_valid)
      await_write_data <= write_out_cmd;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      hw_gate_level <= GAK_HW_GATE_RESET;
      hw_reset_level <= GAK_HW_RESET_RESET;
    end
    else if (write_out_data)
    begin
      hw_gate_level <= host_byte.value[GAK_DATA_GATE];
      hw_reset_level <= host_byte.value[GAK_DATA_RESET];
    end
  end

  assign kbc_pulse_start = pulse_reset_cmd && hw_kbd_reset_enable;

  // ---------------------------------------------------------------
  // reset pulse timers
  // ---------------------------------------------------------------
  // index 0 is the controller path, index 1 the fast register
  assign pulse_start = {fast_pulse_start, kbc_pulse_start};
  // disabling a path also aborts a pulse in flight, so no stale pulse appears later
  assign pulse_cancel = {!fast_port_enable, !hw_kbd_reset_enable};
  assign kbc_pulse_low = pulse_low[0];
  assign kbc_pulse_busy = pulse_busy[0];
  assign fast_pulse_low = pulse_low[1];
  assign fast_pulse_busy = pulse_busy[1];

  for (genvar i = 0; i < 2; i++)
  begin : g_pulser
    gak_reset_pulser #(
      .CNT_W(GAK_CNT_W)
    ) u_pulser (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(kbc_tick),
      .delay_cnt(delay_cnt),
      .pulse_cnt(pulse_cnt),
      .start(pulse_start[i]),
      .cancel(pulse_cancel[i]),
      .pulse_low(pulse_low[i]),
      .busy(pulse_busy[i])
    );
  end

  // ---------------------------------------------------------------
  // source selection and merge
  // ---------------------------------------------------------------
  // hardware path and firmware level never drive an output together
  always_comb
  begin
    if (hw_addr_gate_enable)
      kbc_gate_req = hw_gate_level;
    else
      kbc_gate_req = sw_addr_gate_level;
  end

  always_comb
  begin
    if (hw_kbd_reset_enable)
      kbc_reset_low = !hw_reset_level || kbc_pulse_low;
    else
      kbc_reset_low = !sw_kbd_reset_n;
  end

  assign fast_gate_req = fast_port_enable && soft_addr_gate_level;
  assign fast_reset_low = fast_port_enable && fast_pulse_low;

  assign next_addr_line20_gate = kbc_gate_req || fast_gate_req;
  assign next_kbd_reset_out_n = !(kbc_reset_low || fast_reset_low);

  // registered so that the chipset never sees a decode glitch
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      addr_line20_gate <= 1'b0;
      kbd_reset_out_n <= 1'b1;
    end
    else
    begin
      addr_line20_gate <= next_addr_line20_gate;
      kbd_reset_out_n <= next_kbd_reset_out_n;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_comb
  begin
    status_word = 8'h00;
    status_word[GAK_STS_GATE_OUT] = addr_line20_gate;
    status_word[GAK_STS_RESET_OUT] = !kbd_reset_out_n;
    status_word[GAK_STS_HW_RESET] = hw_reset_level;
    status_word[GAK_STS_HW_GATE] = hw_gate_level;
    status_word[GAK_STS_FAST_BUSY] = fast_pulse_busy;
    status_word[GAK_STS_KBC_BUSY] = kbc_pulse_busy;
    status_word[GAK_STS_AWAIT_DATA] = await_write_data;
  end

  // unmapped addresses read zero; rd_data holds only for the cycle after a read
  always_ff @(posedge ref_clk)
  begin
    if (rst || !bus_req.rd)
      rd_data <= 8'h00;
    else
    begin
      case (bus_req.addr)
        GAK_ADDR_CONFIG: rd_data <= kbd_hw_control_config;
        GAK_ADDR_FAST: rd_data <= fast_a20_reset_port;
        GAK_ADDR_STATUS: rd_data <= status_word;
        default: rd_data <= 8'h00;
      endcase
    end
  end

endmodule : gak_gate_reset_ctrl
`default_nettype wire

// File: bench/gak_gate_reset_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module gak_gate_reset_monitor
  import gak_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire gak_bus_req_type bus_req,
  input wire logic [7:0] rd_data,
  // controller bytes
  input wire logic host_byte_valid,
  input wire gak_host_byte_type host_byte,
  // firmware levels
  input wire logic sw_addr_gate_level,
  input wire logic sw_kbd_reset_n,
  // outputs
  input wire logic addr_line20_gate,
  input wire logic kbd_reset_out_n
);
  logic [7:0] cfg;
  logic [1:0] fast;
  logic d1_wait;
  logic [10:0] since;
  logic [10:0] low_cnt;
  logic start;
  logic d1_data;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  assign d1_data = host_byte_valid && !host_byte.is_command && d1_wait;
  assign start = (host_byte_valid && host_byte.is_command && cfg[0] &&
    host_byte.value == GAK_CMD_PULSE_RESET) || (bus_req.wr && bus_req.addr == GAK_ADDR_FAST &&
    bus_req.wdata[0] && !fast[0] && cfg[2]);

  // shadow copies of the two writable registers
  always_ff @(posedge ref_clk)
    if (rst)
      cfg <= GAK_CONFIG_RESET;
    else if (bus_req.wr && bus_req.addr == GAK_ADDR_CONFIG)
      cfg <= bus_req.wdata & GAK_CONFIG_WMASK;
  always_ff @(posedge ref_clk)
    if (rst)
      fast <= 2'h0;
    else if (bus_req.wr && bus_req.addr == GAK_ADDR_FAST)
      fast <= bus_req.wdata[1:0];
  always_ff @(posedge ref_clk)
    if (rst)
      d1_wait <= 1'b0;
    else if (host_byte_valid)
      d1_wait <= host_byte.is_command && host_byte.value == GAK_CMD_WRITE_OUT;
  // cycles since a pulse request, saturating so old requests fall out of view
  always_ff @(posedge ref_clk)
    if (rst)
      since <= 11'h7FF;
    else if (start)
      since <= 11'h000;
    else if (since != 11'h7FF)
      since <= since + 11'h001;
  always_ff @(posedge ref_clk)
    if (rst || kbd_reset_out_n)
      low_cnt <= 11'h000;
    else if (low_cnt != 11'h7FF)
      low_cnt <= low_cnt + 11'h001;

  fast_fixed_a: assert property (bus_req.rd && bus_req.addr == GAK_ADDR_FAST |=>
    rd_data[7:2] == 6'h09) else $error("fast register fixed bits read wrong");
  cfg_read_a: assert property (bus_req.rd && bus_req.addr == GAK_ADDR_CONFIG |=>
    rd_data == $past(cfg)) else $error("config read differs from written value");
  sw_gate_a: assert property (!$past(cfg[1]) && !$past(cfg[2]) |->
    addr_line20_gate == $past(sw_addr_gate_level)) else $error("gate not from firmware level");
  sw_rst_a: assert property (!$past(cfg[0]) && !$past(cfg[2]) |->
    kbd_reset_out_n == $past(sw_kbd_reset_n)) else $error("reset not from firmware level");
  fast_gate_a: assert property ($past(cfg[2]) && $past(fast[1]) |->
    addr_line20_gate) else $error("fast gate request lost in merge");
  d1_gate_a: assert property (d1_data && cfg[1] && !cfg[2] |-> ##2
    addr_line20_gate == $past(host_byte.value[1], 2)) else $error("gate ignores data bit 1");
  d1_rst_a: assert property (d1_data && cfg[0] && !cfg[2] && since == 11'h7FF |-> ##2
    kbd_reset_out_n == $past(host_byte.value[0], 2)) else $error("reset ignores data bit 0");
  pulse_hold_a: assert property (since < 11'h2BB |-> kbd_reset_out_n)
    else $error("reset pulse came before the least delay");
  pulse_low_a: assert property (start |-> ##[700:1000] !kbd_reset_out_n)
    else $error("reset pulse never came");
  pulse_len_a: assert property ($rose(kbd_reset_out_n) && since < 11'h5DC |->
    low_cnt >= 11'h12C) else $error("reset pulse too short");

  cover property (start && host_byte_valid);
  cover property (start && bus_req.wr);
  cover property (d1_data && cfg[1]);
endmodule : gak_gate_reset_monitor

bind gak_gate_reset_ctrl gak_gate_reset_monitor mon (.ref_clk(ref_clk), .rst(rst),
  .bus_req(bus_req), .rd_data(rd_data), .host_byte_valid(host_byte_valid),
  .host_byte(host_byte), .sw_addr_gate_level(sw_addr_gate_level),
  .sw_kbd_reset_n(sw_kbd_reset_n), .addr_line20_gate(addr_line20_gate),
  .kbd_reset_out_n(kbd_reset_out_n));
`default_nettype wire

// File: bench/gak_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module gak_host_model
  import gak_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // bytes written to the controller
  output logic host_byte_valid,
  output gak_host_byte_type host_byte
);
  initial
  begin
    host_byte_valid = 1'b0;
    host_byte = '0;
  end

  // idle lines carry the inverse of the last byte so a stale value never looks valid
  task automatic send(input logic is_cmd, input logic [7:0] value);
    @(posedge ref_clk);
    host_byte_valid <= 1'b1;
    host_byte <= '{is_command: is_cmd, value: value};
    @(posedge ref_clk);
    host_byte_valid <= 1'b0;
    host_byte <= '{is_command: !is_cmd, value: ~value};
  endtask : send
endmodule : gak_host_model
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import gak_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst;
  gak_bus_req_type bus_req;
  logic sw_addr_gate_level;
  logic sw_kbd_reset_n;
  wire logic [7:0] rd_data;
  wire logic host_byte_valid;
  wire gak_host_byte_type host_byte;
  wire logic addr_line20_gate;
  wire logic kbd_reset_out_n;
  int n_checks = 0;
  int n_mismatch = 0;

  always #10 ref_clk = ~ref_clk;

  gak_gate_reset_ctrl dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .host_byte_valid(host_byte_valid), .host_byte(host_byte),
    .sw_addr_gate_level(sw_addr_gate_level), .sw_kbd_reset_n(sw_kbd_reset_n),
    .addr_line20_gate(addr_line20_gate), .kbd_reset_out_n(kbd_reset_out_n));
  gak_host_model host (.ref_clk(ref_clk), .host_byte_valid(host_byte_valid),
    .host_byte(host_byte));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    check(what, exp, rd_data);
  endtask : rd_chk

  task automatic out_chk(input logic gate, input logic rst_n, input string what);
    wait_cyc(2);
    check({what, " gate"}, {7'h00, gate}, {7'h00, addr_line20_gate});
    check({what, " reset"}, {7'h00, rst_n}, {7'h00, kbd_reset_out_n});
  endtask : out_chk

  // times the pulse from the request edge; a pulse that never ends stops the run
  task automatic pulse_chk(input string what);
    int dly;
    int lowc;
    dly = 0;
    lowc = 0;
    #1;
    while (kbd_reset_out_n === 1'b1 && dly < 2000)
    begin
      @(posedge ref_clk);
      #1 dly++;
    end
    while (kbd_reset_out_n === 1'b0 && lowc < 2000)
    begin
      @(posedge ref_clk);
      #1 lowc++;
    end
    if (dly >= 2000 || lowc >= 2000)
    begin
      n_mismatch++;
      complete_run();
    end
    check({what, " delay"}, 8'h01, {7'h00, dly >= GAK_DELAY_NS / 20 && dly < 800});
    check({what, " low"}, 8'h01, {7'h00, lowc >= GAK_PULSE_NS / 20 && lowc < 400});
  endtask : pulse_chk

  task automatic test_regs;
    rd_chk(GAK_ADDR_CONFIG, GAK_CONFIG_RESET, "config reset");
    rd_chk(GAK_ADDR_FAST, 8'h24, "fast reset");
    reg_wr(GAK_ADDR_FAST, 8'hFE);
    reg_wr(GAK_ADDR_CONFIG, 8'hFE);
    rd_chk(GAK_ADDR_CONFIG, 8'hC6, "config reserved bits");
    rd_chk(GAK_ADDR_FAST, 8'h26, "fast reserved bits");
    rd_chk(8'h10, 8'h00, "unmapped read");
    reg_wr(GAK_ADDR_FAST, 8'h00);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_sw;
    reg_wr(GAK_ADDR_CONFIG, 8'h00);
    reg_wr(GAK_ADDR_FAST, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      sw_addr_gate_level <= i[0];
      sw_kbd_reset_n <= i[1];
      out_chk(i[0], i[1], "firmware path");
    end
    $display("test_sw done");
  endtask : test_sw

  task automatic test_fast_gate;
    @(posedge ref_clk);
    sw_addr_gate_level <= 1'b0;
    reg_wr(GAK_ADDR_CONFIG, 8'h06);
    out_chk(1'b1, 1'b1, "fast gate merged");
    reg_wr(GAK_ADDR_FAST, 8'h00);
    out_chk(1'b0, 1'b1, "fast gate low");
    $display("test_fast_gate done");
  endtask : test_fast_gate

  task automatic test_d1;
    reg_wr(GAK_ADDR_CONFIG, 8'h03);
    host.send(1'b1, GAK_CMD_WRITE_OUT);
    host.send(1'b0, 8'h02);
    out_chk(1'b1, 1'b0, "data after D1");
    host.send(1'b0, 8'h01);
    out_chk(1'b1, 1'b0, "stray data");
    host.send(1'b1, GAK_CMD_WRITE_OUT);
    host.send(1'b1, 8'hA5);
    host.send(1'b0, 8'h01);
    out_chk(1'b1, 1'b0, "cancelled D1");
    host.send(1'b1, GAK_CMD_WRITE_OUT);
    host.send(1'b0, 8'h01);
    out_chk(1'b0, 1'b1, "second D1");
    $display("test_d1 done");
  endtask : test_d1

  task automatic test_fe;
    logic [1:0] codes [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
    foreach (codes[i])
    begin
      reg_wr(GAK_ADDR_CONFIG, {codes[i], 6'h01});
      host.send(1'b1, GAK_CMD_PULSE_RESET);
      pulse_chk("controller pulse");
    end
    host.send(1'b1, GAK_CMD_PULSE_RESET);
    rd_chk(GAK_ADDR_STATUS, 8'h48, "controller pulse busy");
    wait_cyc(1100);
    rd_chk(GAK_ADDR_STATUS, 8'h08, "controller pulse over");
    reg_wr(GAK_ADDR_CONFIG, 8'h00);
    host.send(1'b1, GAK_CMD_PULSE_RESET);
    rd_chk(GAK_ADDR_STATUS, 8'h08, "refused pulse");
    $display("test_fe done");
  endtask : test_fe

  // reset in mid-run, with a fast pulse pending, must bring every register back
  task automatic test_reset;
    reg_wr(GAK_ADDR_CONFIG, 8'h06);
    reg_wr(GAK_ADDR_FAST, 8'h03);
    out_chk(1'b1, 1'b1, "gate before reset");
    wait_cyc(100);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(GAK_ADDR_CONFIG, GAK_CONFIG_RESET, "config after reset");
    rd_chk(GAK_ADDR_FAST, GAK_FAST_RESET, "fast after reset");
    rd_chk(GAK_ADDR_STATUS, 8'h08, "status after reset");
    $display("test_reset done");
  endtask : test_reset

  task automatic test_fast_pulse;
    reg_wr(GAK_ADDR_CONFIG, 8'h04);
    reg_wr(GAK_ADDR_FAST, 8'h01);
    pulse_chk("fast pulse");
    reg_wr(GAK_ADDR_FAST, 8'h00);
    reg_wr(GAK_ADDR_FAST, 8'h01);
    pulse_chk("second fast pulse");
    reg_wr(GAK_ADDR_FAST, 8'h00);
    $display("test_fast_pulse done");
  endtask : test_fast_pulse

  initial
  begin
    rst = 1'b1;
    bus_req = '0;
    sw_addr_gate_level = 1'b0;
    sw_kbd_reset_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    test_regs();
    test_sw();
    test_fast_gate();
    test_d1();
    test_fe();
    test_fast_pulse();
    test_reset();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
